// >>> hdl/asc_pkg.sv
// constants, field layout and state type for the adc sequence control block
// Contract
// - With the repeat-mode bit at 0 one sequence runs and stops; at 1 sequences restart forever.
// - With the multichannel bit at 0 every conversion samples the input named by the select field.
// - With the multichannel bit at 1 a block of four or eight inputs is converted in turn.
// - The sequence-length bit gives four conversions at 0 and eight at 1.
// - Single-channel results fill slots 0 to 3 or 0 to 7 by sequence length.
// - Select codes 0-7 are inputs, 8-11 reserved, 12 high, 13 low, 14 midpoint, 15 test.
// - Input 7 is tied to analog ground, so converting it gives the ground level.
// - Multichannel four-mode uses the top two select bits as block number, results in slots 0-3.
// - Multichannel eight-mode uses only the top select bit, results in slots 0-7.
// - Status holds sequence-complete at 15, pointer at 10:8, complete flags at 7:0, all reset 0.
// - Sequence-complete sets after the first finished sequence and clears on a new start.
// - A slot's complete flag sets when a result lands there and holds until the slot is read.
// - The pointer shows the next slot to be written, the slot of the conversion in progress.
// - A control write starts a new sequence, aborting a running one and clearing all flags.
package asc_pkg;
  localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET = 8'h04;
  localparam logic [7:0]  RESULT_BASE   = 8'h20;
  localparam int          CTRL_W        = 7;
  localparam int          CTRL_SCAN_BIT = 6;
  localparam int          CTRL_MULTICHANNEL_BIT_BIT = 5;
  localparam int          CTRL_LEN_BIT  = 4;
  localparam int          CTRL_SEL_LSB  = 0;
  localparam logic [6:0]  CTRL_RESET    = 7'h00;
  localparam int          STAT_SCF_BIT  = 15;
  localparam int          STAT_PTR_LSB  = 8;
  localparam int          STAT_CCF_LSB  = 0;
  localparam logic [15:0] STATUS_RESET  = 16'h0000;
  localparam int          SLOT_COUNT    = 8;
  localparam logic [2:0]  LAST_SHORT    = 3'h3;
  localparam logic [2:0]  LAST_LONG     = 3'h7;
  localparam logic [3:0]  CODE_GROUND   = 4'h7;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {ASC_IDLE, ASC_ISSUE, ASC_WAIT} asc_state_type;
endpackage

// >>> hdl/asc_top.sv
// adc sequence control: ahb-lite register slave plus conversion sequencer
//
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module asc_top #(
  parameter int RES_W = 10
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  // ahb-lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // converter core and multiplexer
  output logic                  conv_start,
  output logic                  conv_abort,
  output logic      [3:0]       conv_channel,
  output logic                  conv_ground_select,
  input  wire logic             conv_done,
  input  wire logic [RES_W-1:0] conv_result,
  // status
  output logic                  seq_busy
);

  generate
    if (RES_W < 1 || RES_W > 16) begin : g_bad_width
      $error("asc_top: RES_W must lie in 1..16");
    end
  endgenerate

  // reset release through two flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // bus state
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic [31:0] rd_data;
  logic        next_wr_pend;
  logic [7:0]  next_wr_addr;
  logic [31:0] next_rd_data;

  // sequencer state
  asc_pkg::asc_state_type    state;
  asc_pkg::asc_state_type    next_state;
  logic [asc_pkg::CTRL_W-1:0] ctrl;
  logic [asc_pkg::CTRL_W-1:0] next_ctrl;
  logic [2:0]                ptr;
  logic [2:0]                next_ptr;
  logic                      sequence_complete_flag;
  logic                      next_scf;
  logic [7:0]                ccf;
  logic [7:0]                next_ccf;
  logic                      first_seq;
  logic                      next_first_seq;
  logic [RES_W-1:0]          slot      [asc_pkg::SLOT_COUNT];
  logic [RES_W-1:0]          next_slot [asc_pkg::SLOT_COUNT];
  logic                      next_start;
  logic                      next_abort;
  logic [3:0]                next_chan;
  logic                      next_ground;

  // decoded address phase
  logic       acc;
  logic       rd_acc;
  logic       slot_hit;
  logic [7:0] ccf_clear;
  logic       wr_ctrl;
  logic [15:0] status;
  logic       scan;
  logic       multichannel_bit;
  logic       long_seq;
  logic [3:0] sel;
  logic [2:0] last_ptr;
  logic [3:0] chan_code;

  assign scan     = ctrl[asc_pkg::CTRL_SCAN_BIT];
  assign multichannel_bit     = ctrl[asc_pkg::CTRL_MULTICHANNEL_BIT_BIT];
  assign long_seq = ctrl[asc_pkg::CTRL_LEN_BIT];
  assign sel      = ctrl[asc_pkg::CTRL_SEL_LSB +: 4];

  assign acc      = hsel && hready && htrans[1];
  assign rd_acc   = acc && !hwrite;
  assign slot_hit = haddr[7:5] == asc_pkg::RESULT_BASE[7:5];
  assign wr_ctrl  = wr_pend && (wr_addr == asc_pkg::CTRL_OFFSET);

  // zero wait states, never an error
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rd_data;
  assign seq_busy  = state != asc_pkg::ASC_IDLE;

  always_comb begin
    status = asc_pkg::STATUS_RESET;
    status[asc_pkg::STAT_SCF_BIT] = sequence_complete_flag;
    status[asc_pkg::STAT_PTR_LSB +: 3] = ptr;
    status[asc_pkg::STAT_CCF_LSB +: 8] = ccf;
  end

  // sequence length picks the last slot index
  assign last_ptr = long_seq ? asc_pkg::LAST_LONG : asc_pkg::LAST_SHORT;

  // channel code for the conversion about to start
  always_comb begin
    if (!multichannel_bit) begin
      chan_code = sel;
    end else if (long_seq) begin
      chan_code = {sel[3], ptr};
    end else begin
      chan_code = {sel[3:2], ptr[1:0]};
    end
  end

  // reading a result slot clears its flag
  always_comb begin
    ccf_clear = 8'h00;
    if (rd_acc && slot_hit) begin
      ccf_clear[haddr[4:2]] = 1'b1;
    end
  end

  // bus: capture write address, return read data one phase later
  always_comb begin
    next_wr_pend = acc && hwrite;
    next_wr_addr = haddr[7:0];
    next_rd_data = rd_data;
    if (rd_acc) begin
      next_rd_data = 32'h0000_0000;
      if (slot_hit) begin
        next_rd_data[RES_W-1:0] = slot[haddr[4:2]];
      end else if (haddr[7:0] == asc_pkg::CTRL_OFFSET) begin
        next_rd_data[asc_pkg::CTRL_W-1:0] = ctrl;
      end else if (haddr[7:0] == asc_pkg::STATUS_OFFSET) begin
        next_rd_data[15:0] = status;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_data <= 32'h0000_0000;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      rd_data <= next_rd_data;
    end
  end

  // sequencer
  always_comb begin
    logic [7:0] ccf_set;
    ccf_set        = 8'h00;
    next_state     = state;
    next_ctrl      = ctrl;
    next_ptr       = ptr;
    next_scf       = sequence_complete_flag;
    next_first_seq = first_seq;
    next_start     = 1'b0;
    next_abort     = 1'b0;
    next_chan      = conv_channel;
    next_ground    = conv_ground_select;
    for (int i = 0; i < asc_pkg::SLOT_COUNT; i++) begin
      next_slot[i] = slot[i];
    end
    if (wr_ctrl) begin
      // a late result of the aborted conversion is dropped here
      next_ctrl      = hwdata[asc_pkg::CTRL_W-1:0];
      next_abort     = state != asc_pkg::ASC_IDLE;
      next_ptr       = 3'h0;
      next_scf       = 1'b0;
      next_first_seq = 1'b1;
      next_state     = asc_pkg::ASC_ISSUE;
    end else begin
      case (state)
        asc_pkg::ASC_IDLE: begin
          next_state = asc_pkg::ASC_IDLE;
        end
        asc_pkg::ASC_ISSUE: begin
          next_start  = 1'b1;
          next_chan   = chan_code;
          next_ground = chan_code == asc_pkg::CODE_GROUND;
          next_state  = asc_pkg::ASC_WAIT;
        end
        asc_pkg::ASC_WAIT: begin
          if (conv_done) begin
            next_slot[ptr] = conv_result;
            ccf_set[ptr]   = 1'b1;
            if (ptr == last_ptr) begin
              next_ptr = 3'h0;
              if (first_seq) begin
                next_scf = 1'b1;
              end
              next_first_seq = 1'b0;
              next_state = scan ? asc_pkg::ASC_ISSUE : asc_pkg::ASC_IDLE;
            end else begin
              next_ptr   = ptr + 3'h1;
              next_state = asc_pkg::ASC_ISSUE;
            end
          end
        end
        default: begin
          next_state = asc_pkg::ASC_IDLE;
        end
      endcase
    end
    // a new result beats a read clear of the same slot
    next_ccf = wr_ctrl ? 8'h00 : ((ccf & ~ccf_clear) | ccf_set);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state              <= asc_pkg::ASC_IDLE;
      ctrl               <= asc_pkg::CTRL_RESET;
      ptr                <= 3'h0;
      sequence_complete_flag                <= 1'b0;
      ccf                <= 8'h00;
      first_seq          <= 1'b0;
      conv_start         <= 1'b0;
      conv_abort         <= 1'b0;
      conv_channel       <= 4'h0;
      conv_ground_select <= 1'b0;
      for (int i = 0; i < asc_pkg::SLOT_COUNT; i++) begin
        slot[i] <= '0;
      end
    end else begin
      state              <= next_state;
      ctrl               <= next_ctrl;
      ptr                <= next_ptr;
      sequence_complete_flag                <= next_scf;
      ccf                <= next_ccf;
      first_seq          <= next_first_seq;
      conv_start         <= next_start;
      conv_abort         <= next_abort;
      conv_channel       <= next_chan;
      conv_ground_select <= next_ground;
      for (int i = 0; i < asc_pkg::SLOT_COUNT; i++) begin
        slot[i] <= next_slot[i];
      end
    end
  end

endmodule

// >>> sim/asc_conv_model.sv
// behavioural converter core answering each unaborted start after a settable delay
`timescale 1ns/1ps
module asc_conv_model (
  // sequencer side
  input  wire logic       ref_clk,
  input  wire logic       conv_start,
  input  wire logic       conv_abort,
  input  wire logic [3:0] conv_channel,
  input  wire logic       conv_ground_select,
  // bench control
  input  wire logic [3:0] dly,
  // answer
  output logic            conv_done = 1'b0,
  output logic      [9:0] conv_result = 10'h000
);
  logic [4:0] cnt = 5'h00;
  always @(posedge ref_clk) begin
    conv_done <= 1'b0;
    // result is garbage outside the done cycle so a stale sample shows up
    conv_result <= ~conv_result;
    if (conv_start) cnt <= {1'b0, dly} + 5'h01;
    else if (conv_abort) cnt <= 5'h00;
    else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
      if (cnt == 5'h01) begin
        conv_done <= 1'b1;
        conv_result <= conv_ground_select ? 10'h000 : {6'h2A, conv_channel};
      end
    end
  end
endmodule

// >>> sim/asc_top_assertions.sv
// port-level assertions for the adc sequence control block
`timescale 1ns/1ps
module asc_top_assertions (
  // clock, reset, bus
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // converter side
  input wire logic        conv_start,
  input wire logic        conv_abort,
  input wire logic [3:0]  conv_channel,
  input wire logic        conv_ground_select,
  input wire logic        seq_busy
);
  logic take;
  logic wr_ctrl;
  logic rd_stat;
  assign take = hsel && hready && htrans[1];
  assign wr_ctrl = take && hwrite && haddr[7:0] == asc_pkg::CTRL_OFFSET;
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n) rd_stat <= 1'b0;
    else rd_stat <= take && !hwrite && haddr[7:0] == asc_pkg::STATUS_OFFSET;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  AST_GROUND: assert property (conv_ground_select == (conv_channel == 4'h7))
    else $error("ground select not tied to channel 7");
  AST_START: assert property (wr_ctrl |-> ##3 conv_start)
    else $error("no start after control write");
  AST_BUSY: assert property (wr_ctrl |-> ##2 seq_busy)
    else $error("not busy after control write");
  AST_ABORT: assert property (wr_ctrl ##1 seq_busy |-> ##1 conv_abort)
    else $error("running sequence not aborted");
  AST_START_BUSY: assert property (conv_start |-> seq_busy)
    else $error("start while idle");
  AST_PULSE: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  AST_CHAN_HOLD: assert property (!conv_start |-> $stable(conv_channel))
    else $error("channel moved between starts");
  AST_STATUS: assert property (rd_stat |-> hrdata[31:16] == 16'h0000 && hrdata[14:11] == 4'h0)
    else $error("unused status bits set");
endmodule
bind asc_top asc_top_assertions u_chk (.ref_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hrdata, .conv_start, .conv_abort, .conv_channel, .conv_ground_select, .seq_busy);

// >>> sim/tb_top.sv
// self-checking bench for the adc sequence control block
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk = 1'b0;
  logic        arst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic        conv_start, conv_abort, gnd, conv_done, seq_busy;
  logic [1:0]  htrans;
  logic [3:0]  chan, dly;
  logic [9:0]  res;
  logic [31:0] haddr, hwdata, hrdata;
  int          err_count = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [6:0]  codes [9] = '{7'h03, 7'h17, 7'h0C, 7'h20, 7'h24, 7'h28, 7'h2C, 7'h30, 7'h38};
  assign hready = hreadyout;
  always #5 ref_clk = ~ref_clk;
  asc_top u_asc_top (.ref_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .conv_start, .conv_abort, .conv_channel(chan),
    .conv_ground_select(gnd), .conv_done, .conv_result(res), .seq_busy);
  asc_conv_model u_asc_conv_model (.ref_clk, .conv_start, .conv_abort, .conv_channel(chan),
    .conv_ground_select(gnd), .dly, .conv_done, .conv_result(res));
  task automatic stop_test();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= asc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic wait_idle();
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 500 && seq_busy !== 1'b0; i++) @(posedge ref_clk);
  endtask
  // one single-shot sequence, then each slot of the sequence and the flag clearing
  task automatic t_seq(input logic [6:0] c);
    logic [3:0] ch;
    int         n;
    n = c[4] ? 8 : 4;
    wr(8'h00, {25'h0, c});
    wait_idle();
    rd(8'h00, {25'h0, c});
    rd(8'h04, n == 8 ? 32'h80FF : 32'h800F);
    for (int i = 0; i < n; i++) begin
      ch = !c[5] ? c[3:0] : (c[4] ? {c[3], i[2:0]} : {c[3:2], i[1:0]});
      rd(8'(32'h20 + 4 * i), ch == 4'h7 ? 32'h0 : {22'h0, 6'h2A, ch});
    end
    rd(8'h04, 32'h8000);
  endtask
  // repeat mode with a slow core, then an aborting write
  task automatic t_scan();
    logic [31:0] q;
    dly <= 4'h9;
    wr(8'h00, 32'h42);
    repeat (150) @(posedge ref_clk);
    chk({31'h0, seq_busy}, 32'h1);
    bus(1'b0, 8'h04, 32'h0, q);
    chk(q & 32'h8000, 32'h8000);
    rd(8'h20, 32'h2A2);
    dly <= 4'h0;
    wr(8'h00, 32'h01);
    @(posedge ref_clk);
    rd(8'h04, 32'h0);
    wait_idle();
    rd(8'h04, 32'h800F);
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    dly = 4'h0;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(8'h04, 32'h0);
    rd(8'h00, 32'h0);
    wr(8'h04, 32'hFFFFFFFF);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, 32'h0);
    rd(8'h04, 32'h0);
    foreach (codes[i]) t_seq(codes[i]);
    t_scan();
    stop_test();
  end
endmodule
